// ### ccs_pkg.sv
/*
  Constants for the cascaded codec serial port: register map, control
  word fields, channel register fields, reset values and rate tables.
  Assumes a single core clock; every user writes ccs_pkg::name.
*/
package ccs_pkg;
  // Avalon byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ADC1 = 8'h08;
  localparam logic [7:0] OFF_ADC2 = 8'h0C;
  localparam logic [7:0] OFF_DAC1 = 8'h10;
  localparam logic [7:0] OFF_DAC2 = 8'h14;
  localparam logic       RST_ENABLE = 1'b1;
  // Control word fields
  localparam int CW_CTRL   = 15;
  localparam int CW_READ   = 14;
  localparam int CW_DEV_HI = 13;
  localparam int CW_DEV_LO = 11;
  localparam int CW_REG_HI = 10;
  localparam int CW_REG_LO = 8;
  localparam logic [2:0] DEV_SELF = 3'h0;
  localparam logic [2:0] DEV_STEP = 3'h1;
  // Channel register indices
  localparam logic [2:0] REG_A = 3'h0;
  localparam logic [2:0] REG_B = 3'h1;
  localparam logic [2:0] REG_C = 3'h2;
  // Control register A fields
  localparam int CRA_PGM    = 0;
  localparam int CRA_MM     = 1;
  localparam int CRA_CNT_HI = 6;
  localparam int CRA_CNT_LO = 4;
  // Control register B fields
  localparam int CRB_SR_HI = 1;
  localparam int CRB_SR_LO = 0;
  localparam int CRB_SC_HI = 3;
  localparam int CRB_SC_LO = 2;
  localparam int CRB_MD_HI = 6;
  localparam int CRB_MD_LO = 4;
  // Control register C power bits
  localparam int CRC_ADC    = 3;
  localparam int CRC_DAC    = 4;
  localparam int CRC_REF    = 5;
  localparam int CRC_REFERENCE_OUTPUT = 6;
  localparam logic [7:0] RST_CREG = 8'h00;
  // Sample period in divided-clock ticks, minus one, by select code
  localparam logic [10:0] SR_LIM [4] = '{11'h7FF, 11'h3FF, 11'h1FF, 11'h0FF};
  // Serial clock half period in divided-clock ticks, minus one
  localparam logic [1:0] SC_LIM [4] = '{2'h3, 2'h1, 2'h0, 2'h0};
  localparam int WORD_BITS = 16;
  localparam logic [4:0] RX_LEN = 5'h10;
  localparam logic [3:0] TX_LAST = 4'hF;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_BITS = 2'b10
  } ccs_tx_t;
endpackage

// ### ccs_shifter.sv
/*
  One channel's serial register: receives a framed 16-bit word and
  sends a framed word with a one-bit frame sync ahead of the MSB.
  Assumes bit_en is a one-cycle pulse per serial bit on clk.
*/
`timescale 1ns/1ns
module ccs_shifter (
  input  wire logic        clk,       // Core clock
  input  wire logic        rst_n,     // Sync reset, low active
  input  wire logic        bit_en,    // One pulse per serial bit
  input  wire logic        in_fs,     // Frame sync in
  input  wire logic        in_bit,    // Serial data in
  input  wire logic        load,      // Take load_word
  input  wire logic [15:0] load_word, // Word to send
  output logic             out_fs,    // Frame sync out
  output logic             out_bit,   // Serial data out
  output logic      [15:0] rx_word,   // Last word received
  output logic             rx_done,   // Word complete pulse
  output logic             ready      // Hold slot free
);
  logic [4:0]         rx_cnt_reg;
  logic [15:0]        hold_reg;
  logic               hold_v_reg;
  logic [15:0]        sh_reg;
  logic [3:0]         tx_cnt_reg;
  ccs_pkg::ccs_tx_t   tx_st_reg;

  assign ready = ~hold_v_reg;

  // Receive: arm on frame sync, take MSB first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_cnt_reg <= 5'h00;
      rx_word    <= 16'h0000;
      rx_done    <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (bit_en) begin
        if (rx_cnt_reg != 5'h00) begin
          rx_word    <= {rx_word[14:0], in_bit};
          rx_cnt_reg <= rx_cnt_reg - 5'h01;
          rx_done    <= (rx_cnt_reg == 5'h01);
        end else if (in_fs) begin
          rx_cnt_reg <= ccs_pkg::RX_LEN;
        end
      end
    end
  end

  // One-word hold so a forward can queue behind a running send
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_reg   <= 16'h0000;
      hold_v_reg <= 1'b0;
    end else if (load && !hold_v_reg) begin
      hold_reg   <= load_word;
      hold_v_reg <= 1'b1;
    end else if (bit_en && tx_st_reg == ccs_pkg::TX_IDLE) begin
      hold_v_reg <= 1'b0;
    end
  end

  // Transmit: sync bit, then 16 data bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_st_reg  <= ccs_pkg::TX_IDLE;
      sh_reg     <= 16'h0000;
      tx_cnt_reg <= 4'h0;
      out_fs     <= 1'b0;
      out_bit    <= 1'b0;
    end else if (bit_en) begin
      unique case (tx_st_reg)
        ccs_pkg::TX_IDLE: begin
          out_bit <= 1'b0;
          if (hold_v_reg) begin
            out_fs    <= 1'b1;
            sh_reg    <= hold_reg;
            tx_st_reg <= ccs_pkg::TX_SYNC;
          end
        end
        ccs_pkg::TX_SYNC: begin
          out_fs     <= 1'b0;
          out_bit    <= sh_reg[15];
          sh_reg     <= {sh_reg[14:0], 1'b0};
          tx_cnt_reg <= ccs_pkg::TX_LAST;
          tx_st_reg  <= ccs_pkg::TX_BITS;
        end
        ccs_pkg::TX_BITS: begin
          if (tx_cnt_reg == 4'h1) begin
            tx_st_reg <= ccs_pkg::TX_IDLE;
          end
          out_bit    <= sh_reg[15];
          sh_reg     <= {sh_reg[14:0], 1'b0};
          tx_cnt_reg <= tx_cnt_reg - 4'h1;
        end
        default: tx_st_reg <= ccs_pkg::TX_IDLE;
      endcase
    end
  end
endmodule // ccs_shifter

// ### ccs_top.sv
/*
  Two-channel cascaded serial port: channel 1 faces the DSP input pins,
  channel 2 drives the DSP output pins, with an Avalon-MM slave for
  ADC words, DAC readout and port status.
  Assumes serial pins are asynchronous and a 20 MHz core clock.
*/
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ns
// Overview of operation
// - First sample event after reset: both channels raise output sync together.
// - A word not addressed here is sent onward under a raised output sync.
// - Forwarded control words get their address field decremented.
// - A register A write with count two and both mode bits gives mixed mode.
// - In mixed mode, MSB 0 means DAC data, else control.
// - DAC loads once input syncs with DAC words reach the device count.
// - Control bit 14 set requests readback of the addressed register.
// - Readback words lose one address step per channel passed.
// - Channel 1 register B sets divided clock, sample rate and serial clock.
// - Register C powers analog sections; early ADC words still travel.
// - Without loopback, control and DAC update fit one sample period.
// - With loopback, the ADC word after a control write acts as control.
// - After a DAC update the sync counter clears and counts again.
// - In mixed mode only MSB-zero words advance the sync counter.
module ccs_top (
  input  wire logic        CORE_CLK,             // 20 MHz core clock
  input  wire logic        RESET_N,              // Sync reset, low active
  input  wire logic [7:0]  AVS_ADDRESS,          // Byte address
  input  wire logic [3:0]  AVS_BYTEENABLE,       // Byte lanes
  input  wire logic        AVS_READ,             // Read request
  input  wire logic        AVS_WRITE,            // Write request
  input  wire logic [31:0] AVS_WRITEDATA,        // Write data
  output logic      [31:0] AVS_READDATA,         // Read data
  output logic             AVS_WAITREQUEST,      // Stall
  output logic             SCLK,                 // Serial clock out
  input  wire logic        SDI,                  // Serial data in
  input  wire logic        SERIAL_IN_FRAME_SYNC, // Input frame sync
  output logic             SDO,                  // Serial data out
  output logic             SERIAL_OUT_FRAME_SYNC,// Output frame sync
  input  wire logic        FRAME_SYNC_LOOPBACK,  // Loopback wiring strap
  output logic      [15:0] DAC_CH1_DATA,         // Channel 1 DAC word
  output logic      [15:0] DAC_CH2_DATA,         // Channel 2 DAC word
  output logic      [1:0]  DAC_UPDATE,           // DAC load pulses
  output logic      [1:0]  ADC_ON,               // ADC powered
  output logic      [1:0]  DAC_ON,               // DAC powered
  output logic      [1:0]  REF_ON,               // Reference powered
  output logic      [1:0]  REFERENCE_OUTPUT_ON             // Reference output on
);
  logic              sdi_m_reg, sdi_q_reg;
  logic              fs_m_reg, fs_q_reg;
  logic              lb_m_reg, lb_q_reg;
  logic              enable_reg;
  logic [15:0]       adc_reg [2];
  logic              ack_reg;
  logic [2:0]        md_cnt_reg;
  logic [1:0]        sc_cnt_reg;
  logic [10:0]       smp_cnt_reg;
  logic              sclk_reg;
  logic              smp_tick_reg;
  logic              dm_en, half_en, bit_en;
  logic [7:0]        control_reg_b;
  logic [1:0]        in_fs, in_bit, out_fs, out_bit;
  logic [1:0]        tx_load, tx_ready, rx_done;
  logic [1:0][15:0]  rx_word, tx_word, dac_q;
  logic [1:0][7:0]   cra_q, crb_q, crc_q;
  logic [1:0][3:0]   fcnt_q;
  logic              req;
  logic [31:0]       rd_next;

  // Two flops on the SDI, input frame sync and loopback strap pins; only the second is read
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      sdi_m_reg <= 1'b0;
      sdi_q_reg <= 1'b0;
      fs_m_reg  <= 1'b0;
      fs_q_reg  <= 1'b0;
      lb_m_reg  <= 1'b0;
      lb_q_reg  <= 1'b0;
    end else begin
      sdi_m_reg <= SDI;
      sdi_q_reg <= sdi_m_reg;
      fs_m_reg  <= SERIAL_IN_FRAME_SYNC;
      fs_q_reg  <= fs_m_reg;
      lb_m_reg  <= FRAME_SYNC_LOOPBACK;
      lb_q_reg  <= lb_m_reg;
    end
  end

  // Timing follows channel 1 register B; channel 2 register B sets nothing
  assign control_reg_b     = crb_q[0];
  assign dm_en   = (md_cnt_reg == control_reg_b[ccs_pkg::CRB_MD_HI:ccs_pkg::CRB_MD_LO]);
  assign half_en = dm_en && (sc_cnt_reg == ccs_pkg::SC_LIM[control_reg_b[ccs_pkg::CRB_SC_HI:ccs_pkg::CRB_SC_LO]]);
  assign bit_en  = half_en && sclk_reg;

  // Master clock divider; field 0 keeps divided clock equal to core
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || dm_en) begin
      md_cnt_reg <= 3'h0;
    end else begin
      md_cnt_reg <= md_cnt_reg + 3'h1;
    end
  end

  // Serial clock: data launches and samples on the falling edge
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      sc_cnt_reg <= 2'h0;
      sclk_reg   <= 1'b0;
    end else if (half_en) begin
      sc_cnt_reg <= 2'h0;
      sclk_reg   <= ~sclk_reg;
    end else if (dm_en) begin
      sc_cnt_reg <= sc_cnt_reg + 2'h1;
    end
  end

  assign SCLK = sclk_reg;

  // Sample event counter, gated by the software enable
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      smp_cnt_reg  <= 11'h000;
      smp_tick_reg <= 1'b0;
    end else begin
      smp_tick_reg <= 1'b0;
      if (enable_reg && dm_en) begin
        if (smp_cnt_reg == ccs_pkg::SR_LIM[control_reg_b[ccs_pkg::CRB_SR_HI:ccs_pkg::CRB_SR_LO]]) begin
          smp_cnt_reg  <= 11'h000;
          smp_tick_reg <= 1'b1;
        end else begin
          smp_cnt_reg <= smp_cnt_reg + 11'h001;
        end
      end
    end
  end

  // Cascade wiring: channel 1 output sync is channel 2 input sync
  assign in_fs[0]              = fs_q_reg;
  assign in_bit[0]             = sdi_q_reg;
  assign in_fs[1]              = out_fs[0];
  assign in_bit[1]             = out_bit[0];
  assign SDO                   = out_bit[1];
  assign SERIAL_OUT_FRAME_SYNC = out_fs[1];

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : gen_ch
      logic [7:0]  creg_reg [8];
      logic [3:0]  fcnt_reg;
      logic [15:0] dac_reg;
      logic        upd_reg;
      logic        fwd_v_reg;
      logic [15:0] fwd_w_reg;
      logic        smp_pend_reg;
      logic        lb_pend_reg;
      logic [15:0] w;
      logic        is_ctrl, is_self, do_wr, do_rd, do_fwd, do_dat, dac_hit, prog, do_pass;
      logic [3:0]  dev_cnt, cnt_nxt;
      logic [2:0]  rsel;

      assign w       = rx_word[c];
      assign rsel    = w[ccs_pkg::CW_REG_HI:ccs_pkg::CW_REG_LO];
      assign prog    = !creg_reg[ccs_pkg::REG_A][ccs_pkg::CRA_PGM];
      // Program and mixed modes: MSB marks control; data mode none; loopback override
      assign is_ctrl = ((prog || creg_reg[ccs_pkg::REG_A][ccs_pkg::CRA_MM])
                        && w[ccs_pkg::CW_CTRL])
                     || lb_pend_reg;
      assign is_self = (w[ccs_pkg::CW_DEV_HI:ccs_pkg::CW_DEV_LO] == ccs_pkg::DEV_SELF);
      assign do_wr   = rx_done[c] && is_ctrl && is_self && !w[ccs_pkg::CW_READ];
      assign do_rd   = rx_done[c] && is_ctrl && is_self && w[ccs_pkg::CW_READ];
      assign do_fwd  = rx_done[c] && is_ctrl && !is_self;
      assign do_dat  = rx_done[c] && !is_ctrl && !prog;
      // Program mode data words only travel, so upstream ADC words arrive intact
      assign do_pass = rx_done[c] && !is_ctrl && prog;
      assign dev_cnt = {1'b0, creg_reg[ccs_pkg::REG_A][ccs_pkg::CRA_CNT_HI:ccs_pkg::CRA_CNT_LO]}
                     + 4'h1;
      assign cnt_nxt = fcnt_reg + 4'h1;
      assign dac_hit = do_dat && (cnt_nxt == dev_cnt);
      // Forwarded words take priority; the sample word waits its turn
      assign tx_load[c] = tx_ready[c] && (fwd_v_reg || smp_pend_reg);
      assign tx_word[c] = fwd_v_reg ? fwd_w_reg : adc_reg[c];

      // Channel registers; mode bits of A steer decoding at once
      always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
          for (int i = 0; i < 8; i++) begin
            creg_reg[i] <= ccs_pkg::RST_CREG;
          end
        end else if (do_wr) begin
          creg_reg[rsel] <= w[7:0];
        end
      end

      // Frame sync counter restarts after each DAC load
      always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || dac_hit) begin
          fcnt_reg <= 4'h0;
        end else if (do_dat) begin
          fcnt_reg <= cnt_nxt;
        end
      end

      // DAC holds the word that completed the count
      always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
          dac_reg <= 16'h0000;
          upd_reg <= 1'b0;
        end else begin
          upd_reg <= dac_hit;
          if (dac_hit) begin
            dac_reg <= w;
          end
        end
      end

      // Onward word: control and readback lose one address step
      always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
          fwd_v_reg <= 1'b0;
          fwd_w_reg <= 16'h0000;
        end else if (do_fwd || do_rd) begin
          fwd_v_reg <= 1'b1;
          fwd_w_reg <= {w[15:14], w[ccs_pkg::CW_DEV_HI:ccs_pkg::CW_DEV_LO] - ccs_pkg::DEV_STEP,
                        rsel, do_rd ? creg_reg[rsel] : w[7:0]};
        end else if (do_pass || (do_dat && !dac_hit)) begin
          fwd_v_reg <= 1'b1;
          fwd_w_reg <= w;
        end else if (tx_load[c] && fwd_v_reg) begin
          fwd_v_reg <= 1'b0;
        end
      end

      // Sample word pending; a new tick wins over the clear
      always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
          smp_pend_reg <= 1'b0;
        end else if (smp_tick_reg) begin
          smp_pend_reg <= 1'b1;
        end else if (tx_load[c] && !fwd_v_reg) begin
          smp_pend_reg <= 1'b0;
        end
      end

      // With loopback the next returning word is read as control
      always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
          lb_pend_reg <= 1'b0;
        end else if (do_wr && lb_q_reg) begin
          lb_pend_reg <= 1'b1;
        end else if (rx_done[c]) begin
          lb_pend_reg <= 1'b0;
        end
      end

      ccs_shifter u_shifter (
        .clk       (CORE_CLK),
        .rst_n     (RESET_N),
        .bit_en    (bit_en),
        .in_fs     (in_fs[c]),
        .in_bit    (in_bit[c]),
        .load      (tx_load[c]),
        .load_word (tx_word[c]),
        .out_fs    (out_fs[c]),
        .out_bit   (out_bit[c]),
        .rx_word   (rx_word[c]),
        .rx_done   (rx_done[c]),
        .ready     (tx_ready[c])
      );

      assign dac_q[c]      = dac_reg;
      assign cra_q[c]      = creg_reg[ccs_pkg::REG_A];
      assign crb_q[c]      = creg_reg[ccs_pkg::REG_B];
      assign crc_q[c]      = creg_reg[ccs_pkg::REG_C];
      assign fcnt_q[c]     = fcnt_reg;
      assign DAC_UPDATE[c] = upd_reg;
      assign ADC_ON[c]     = crc_q[c][ccs_pkg::CRC_ADC];
      assign DAC_ON[c]     = crc_q[c][ccs_pkg::CRC_DAC];
      assign REF_ON[c]     = crc_q[c][ccs_pkg::CRC_REF];
      assign REFERENCE_OUTPUT_ON[c]  = crc_q[c][ccs_pkg::CRC_REFERENCE_OUTPUT];
    end
  endgenerate

  assign DAC_CH1_DATA = dac_q[0];
  assign DAC_CH2_DATA = dac_q[1];

  // One wait state per access; write lands on the ack edge
  assign req             = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = req && !ack_reg;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_next = 32'h00000000;
    unique case (AVS_ADDRESS)
      ccs_pkg::OFF_CTRL: rd_next = {31'h00000000, enable_reg};
      ccs_pkg::OFF_STAT: rd_next = {19'h00000, lb_q_reg,
                                    cra_q[1][1:0], cra_q[0][1:0], fcnt_q[1], fcnt_q[0]};
      ccs_pkg::OFF_ADC1: rd_next = {16'h0000, adc_reg[0]};
      ccs_pkg::OFF_ADC2: rd_next = {16'h0000, adc_reg[1]};
      ccs_pkg::OFF_DAC1: rd_next = {16'h0000, dac_q[0]};
      ccs_pkg::OFF_DAC2: rd_next = {16'h0000, dac_q[1]};
      default:           rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ && !ack_reg) begin
      AVS_READDATA <= rd_next;
    end
  end

  // Software registers, byte lanes honoured
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      enable_reg <= ccs_pkg::RST_ENABLE;
      adc_reg[0] <= 16'h0000;
      adc_reg[1] <= 16'h0000;
    end else if (AVS_WRITE && ack_reg) begin
      for (int i = 0; i < 2; i++) begin
        if (AVS_ADDRESS == (i == 0 ? ccs_pkg::OFF_ADC1 : ccs_pkg::OFF_ADC2)) begin
          if (AVS_BYTEENABLE[0]) adc_reg[i][7:0]  <= AVS_WRITEDATA[7:0];
          if (AVS_BYTEENABLE[1]) adc_reg[i][15:8] <= AVS_WRITEDATA[15:8];
        end
      end
      if (AVS_ADDRESS == ccs_pkg::OFF_CTRL && AVS_BYTEENABLE[0]) begin
        enable_reg <= AVS_WRITEDATA[0];
      end
    end
  end
endmodule // ccs_top

// ### ccs_checker.sv
/* Port checks for ccs_top: Avalon handshake, serial clock, framing and
   DAC load pulses. Assumes register B keeps its reset value. */
`timescale 1ns/1ns
module ccs_checker (
  input wire logic        CORE_CLK,              // Clock
  input wire logic        RESET_N,               // Reset
  input wire logic [7:0]  AVS_ADDRESS,           // Address
  input wire logic        AVS_READ,              // Read
  input wire logic        AVS_WRITE,             // Write
  input wire logic [31:0] AVS_READDATA,          // Read data
  input wire logic        AVS_WAITREQUEST,       // Stall
  input wire logic        SCLK,                  // Serial clock
  input wire logic        SDO,                   // Serial out
  input wire logic        SERIAL_OUT_FRAME_SYNC, // Out sync
  input wire logic [15:0] DAC_CH1_DATA,          // DAC 1
  input wire logic [15:0] DAC_CH2_DATA,          // DAC 2
  input wire logic [1:0]  DAC_UPDATE             // Load pulses
);
  // One clock domain, checks quiet in reset
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  // Avalon: exactly one wait state, none while idle
  a_one_wait: assert property ($rose(AVS_READ || AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait state count wrong");
  a_idle_nostall: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("stall while idle");
  // Unmapped space reads zero; read data holds past the handshake
  a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS >= 8'h18 |-> AVS_READDATA == 32'h00000000) else $error("unmapped nonzero");
  a_data_stands: assert property (AVS_READ && !AVS_WAITREQUEST |=> $stable(AVS_READDATA))
    else $error("read data moved");
  // Serial clock half period is four core cycles at reset divide
  a_sclk_half: assert property ($rose(SCLK) |=> SCLK[*3] ##1 !SCLK)
    else $error("serial clock rate wrong");
  // Output sync lasts one bit; line rests low after the sixteenth bit
  a_sync_width: assert property ($rose(SERIAL_OUT_FRAME_SYNC) |->
    SERIAL_OUT_FRAME_SYNC[*8] ##1 !SERIAL_OUT_FRAME_SYNC) else $error("sync width wrong");
  a_sdo_rests: assert property ($rose(SERIAL_OUT_FRAME_SYNC) |-> ##140 !SDO)
    else $error("data line not low after word");
  // A new DAC word comes with a single load pulse in the same cycle
  a_dac1_load: assert property ($changed(DAC_CH1_DATA) |->
    DAC_UPDATE[0] ##1 !DAC_UPDATE[0]) else $error("channel 1 load pulse wrong");
  a_dac2_load: assert property ($changed(DAC_CH2_DATA) |->
    DAC_UPDATE[1] ##1 !DAC_UPDATE[1]) else $error("channel 2 load pulse wrong");
endmodule // ccs_checker

bind ccs_top ccs_checker u_chk (.CORE_CLK, .RESET_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_READDATA, .AVS_WAITREQUEST, .SCLK, .SDO, .SERIAL_OUT_FRAME_SYNC, .DAC_CH1_DATA,
  .DAC_CH2_DATA, .DAC_UPDATE);

// ### ccs_dsp.sv
/* DSP serial port model: collects framed words from the cascade and
   sends queued words, each led by a one-bit sync, with no gap.
   Assumes both directions move on the rising serial clock. */
`timescale 1ns/1ns
module ccs_dsp (
  input wire logic sclk,   // Serial clock
  input wire logic rx_bit, // Cascade data out
  input wire logic rx_fs,  // Cascade sync out
  output logic     tx_bit, // Cascade data in
  output logic     tx_fs   // Cascade sync in
);
  logic [15:0] rx_q[$];
  logic [15:0] tx_q[$];
  logic [15:0] rx_sr;
  logic [15:0] tx_sr;
  int          rx_cnt = 0;
  int          tx_cnt = 0;

  // Lines idle at time zero
  initial begin
    tx_bit = 1'b0;
    tx_fs  = 1'b0;
  end

  // Sixteen bits follow each received sync, MSB first
  always @(posedge sclk) begin
    if (rx_cnt > 0) begin
      rx_sr = {rx_sr[14:0], rx_bit};
      rx_cnt--;
      if (rx_cnt == 0) begin
        rx_q.push_back(rx_sr);
      end
    end else if (rx_fs) begin
      rx_cnt = 16;
    end
  end

  // Queued words leave back to back; idle data toggles so no stale bit lingers
  always @(posedge sclk) begin
    tx_fs <= 1'b0;
    if (tx_cnt > 0) begin
      tx_bit <= tx_sr[15];
      tx_sr = {tx_sr[14:0], 1'b0};
      tx_cnt--;
    end else begin
      tx_bit <= ~tx_bit;
      if (tx_q.size() > 0) begin
        tx_sr = tx_q.pop_front();
        tx_fs <= 1'b1;
        tx_cnt = 16;
      end
    end
  end
endmodule // ccs_dsp

// ### ccs_top_tb.sv
/* Self-checking bench for ccs_top: register access, first sample event,
   control forwarding, readback and mixed-mode DAC loads.
   Assumes the DSP model on the serial pins; loopback strap set last. */
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
module ccs_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  be = 4'hF;
  logic        lb = 1'b0;
  logic [31:0] rdata, q;
  logic        waitreq, sclk, sdi, sifs, sdo, sofs;
  logic [15:0] dac1, dac2;
  logic [1:0]  upd, adc_on, dac_on, ref_on, refo_on;
  logic [15:0] w [2];
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          n_upd1 = 0;
  int          n_upd2 = 0;

  ccs_top dut (.CORE_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_BYTEENABLE(be),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .SCLK(sclk), .SDI(sdi), .SERIAL_IN_FRAME_SYNC(sifs),
    .SDO(sdo), .SERIAL_OUT_FRAME_SYNC(sofs), .FRAME_SYNC_LOOPBACK(lb),
    .DAC_CH1_DATA(dac1), .DAC_CH2_DATA(dac2), .DAC_UPDATE(upd), .ADC_ON(adc_on),
    .DAC_ON(dac_on), .REF_ON(ref_on), .REFERENCE_OUTPUT_ON(refo_on));
  ccs_dsp u_dsp (.sclk(sclk), .rx_bit(sdo), .rx_fs(sofs), .tx_bit(sdi), .tx_fs(sifs));

  // Core clock, 50 ns period
  always #25 clk = ~clk;

  // Hang guard, about ten sample periods of work; DAC load pulse tally
  always @(posedge clk) begin
    cycles++;
    n_upd1 += int'(upd[0] === 1'b1);
    n_upd2 += int'(upd[1] === 1'b1);
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    rd    <= ~we;
    wr    <= we;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Next two words reaching the DSP
  task automatic get2();
    while (u_dsp.rx_q.size() < 2) @(posedge clk);
    w[0] = u_dsp.rx_q.pop_front();
    w[1] = u_dsp.rx_q.pop_front();
  endtask

  // Sample words: channel 2 first, channel 1 passed on intact
  task automatic t_first();
    bus(1'b1, 8'h08, 32'h00001234);
    bus(1'b1, 8'h0C, 32'h00000500);
    be <= 4'h1;
    bus(1'b1, 8'h0C, 32'h0000FF67); // Low lane only, upper byte kept
    be <= 4'hF;
    bus(1'b0, 8'h08, 32'h0);
    `CHK("adc1 reg", 16'h1234, q[15:0])
    bus(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 32'h00000000, q)
    get2();
    `CHK("first ch2 word", 16'h0567, w[0])
    `CHK("first ch1 word", 16'h1234, w[1])
  endtask

  // Register C writes; channel 2 only sees its word if the address steps down
  task automatic t_power();
    get2();
    u_dsp.tx_q.push_back(16'h8A78);
    u_dsp.tx_q.push_back(16'h8278);
    while (adc_on !== 2'b11) @(posedge clk);
    `CHK("dac power", 2'b11, dac_on)
    `CHK("ref power", 2'b11, ref_on)
    `CHK("ref out", 2'b11, refo_on)
    `CHK("no echo", 1'b1, u_dsp.rx_q.size() == 0)
  endtask

  // Register C readback from both channels
  task automatic t_readback();
    get2();
    u_dsp.tx_q.push_back(16'hCA00);
    u_dsp.tx_q.push_back(16'hC200);
    get2();
    `CHK("ch2 readback", 16'hFA78, w[0])
    `CHK("ch1 readback", 16'hF278, w[1])
  endtask

  // Mixed mode: control word between data words does not advance the count
  task automatic t_mixed();
    get2();
    u_dsp.tx_q.push_back(16'h8813);
    u_dsp.tx_q.push_back(16'h8013);
    do bus(1'b0, 8'h04, 32'h0); while (q[11:8] !== 4'hF);
    `CHK("mode bits", 5'h0F, q[12:8])
    get2();
    `CHK("data word passed", 16'h1234, w[1])
    u_dsp.tx_q.push_back(16'h0ABC);
    u_dsp.tx_q.push_back(16'h8208);
    u_dsp.tx_q.push_back(16'h0DEF);
    while (n_upd1 == 0 || n_upd2 == 0) @(posedge clk);
    `CHK("ch1 dac", 16'h0DEF, dac1)
    `CHK("ch2 dac", 16'h0ABC, dac2)
    `CHK("ch1 dac off", 2'b10, dac_on)
    bus(1'b0, 8'h04, 32'h0);
    `CHK("counters", 8'h00, q[7:0])
    `CHK("one load each", 1'b1, n_upd1 == 1 && n_upd2 == 1)
  endtask

  // Loopback strap: after a control write the returning ADC word acts as control
  task automatic t_loop();
    lb <= 1'b1;
    u_dsp.tx_q.push_back(16'h8A78);
    u_dsp.tx_q.push_back(16'h8278);
    get2();
    `CHK("loop ch2 word", 16'h0567, w[0])
    `CHK("loop ch1 word", 16'h0A34, w[1])
  endtask

  // Verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reset, then each scenario in turn
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_first();
    t_power();
    t_readback();
    t_mixed();
    t_loop();
    test_done();
  end
endmodule // ccs_top_tb
